// ---- verilog/drive_status_parameter_bank.sv ----
// Read-only status parameter bank of the integrated drive.
// Assumes drive core inputs are on i_clk; SAFE_TORQUE_OFF and local I/O pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module drive_status_parameter_bank
   import status_bank_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // Parameter access port from the fieldbus side
   input  wire logic        i_par_rd,
   input  wire logic        i_par_wr,
   input  wire logic [15:0] i_par_addr,
   input  wire logic [31:0] i_par_wdata,
   output logic      [31:0] o_par_rdata,
   output logic             o_par_ack,
   output logic             o_par_err,
   // Drive core status
   input  wire logic        i_excl_access,
   input  wire logic [7:0]  i_access_channel,
   input  wire logic [4:0]  i_error_class_active,
   input  wire logic [1:0]  i_pg_state,
   input  wire logic [15:0] i_op_mode,
   input  wire logic [47:0] i_mac_address,
   input  wire logic        i_sto_present,
   input  wire logic        i_sto_connected,
   input  wire logic        i_local_signal_one,
   input  wire logic        i_local_signal_two,
   input  wire logic        i_class0_event,
   input  wire logic [15:0] i_class0_code,
   input  wire logic        i_fault_reset,
   input  wire logic [15:0] i_overload_pct,
   input  wire logic [15:0] i_load_pct,
   input  wire logic [15:0] i_torque_current_actual,
   input  wire logic [15:0] i_field_current_actual,
   input  wire logic [15:0] i_idq_act,
   input  wire logic [15:0] i_velocity,
   input  wire logic [15:0] i_torque_current_reference,
   input  wire logic [15:0] i_field_current_reference,
   input  wire logic [31:0] i_ramp_velocity,
   input  wire logic [31:0] i_ramp_velocity_prev
);

   // ****************************************
   // Local functions
   // ****************************************

   // Magnitude of a signed 16-bit value
   function automatic logic [15:0] mag16(input logic [15:0] v);
      mag16 = v[15] ? 16'(~v + 16'h0001) : v;
   endfunction

   // Check a mode code against the legal set
   function automatic logic mode_legal(input logic [15:0] m);
      mode_legal = (m == MODE_SPEED) || (m == MODE_JOG) || (m == MODE_PROFILE_POS)
                || (m == MODE_PROFILE_VEL) || (m == MODE_HOMING);
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] sync_sto_p_r;
   logic [2:0] sync_sto_c_r;
   logic [2:0] sync_local_signal_one_r;
   logic [2:0] sync_local_signal_two_r;
   logic       sto_p_r;
   logic       sto_c_r;
   logic       local_signal_one_r;
   logic       local_signal_two_r;

   // Three stages; accept a change once stages two and three agree
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync_sto_p_r <= 3'h0;
         sync_sto_c_r <= 3'h0;
         sync_local_signal_one_r  <= 3'h0;
         sync_local_signal_two_r  <= 3'h0;
      end else begin
         sync_sto_p_r <= {sync_sto_p_r[1:0], i_sto_present};
         sync_sto_c_r <= {sync_sto_c_r[1:0], i_sto_connected};
         sync_local_signal_one_r  <= {sync_local_signal_one_r[1:0], i_local_signal_one};
         sync_local_signal_two_r  <= {sync_local_signal_two_r[1:0], i_local_signal_two};
      end
   end

   // Filtered pin levels
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sto_p_r <= 1'b0;
         sto_c_r <= 1'b0;
         local_signal_one_r  <= 1'b0;
         local_signal_two_r  <= 1'b0;
      end else begin
         if (sync_sto_p_r[1] == sync_sto_p_r[2]) sto_p_r <= sync_sto_p_r[2];
         if (sync_sto_c_r[1] == sync_sto_c_r[2]) sto_c_r <= sync_sto_c_r[2];
         if (sync_local_signal_one_r[1] == sync_local_signal_one_r[2]) local_signal_one_r <= sync_local_signal_one_r[2];
         if (sync_local_signal_two_r[1] == sync_local_signal_two_r[2]) local_signal_two_r <= sync_local_signal_two_r[2];
      end
   end

   // ****************************************
   // Next values of the status words
   // ****************************************
   logic [15:0] access_nxt;
   logic [15:0] action_nxt;
   logic [15:0] mode_nxt;
   logic [15:0] sto_nxt;
   logic [15:0] lio_nxt;
   logic [15:0] warn_nxt;
   logic [15:0] warn_r;
   logic [31:0] acc_nxt;
   logic [3:0]  pg_onehot;
   logic        standstill;
   logic        move_pos;
   logic        move_neg;
   pg_state_t   pg_state;

   // Channel code and exclusive flag
   assign access_nxt = {i_access_channel, i_excl_access ? EXCL_HELD : EXCL_NONE};

   // Motion decode from measured velocity
   assign standstill = mag16(i_velocity) < STANDSTILL_RPM;
   assign move_pos   = !standstill && !i_velocity[15];
   assign move_neg   = !standstill && i_velocity[15];

   // Profile generator state to one-hot bits
   assign pg_state  = pg_state_t'(i_pg_state);
   always_comb begin
      case (pg_state)
         PG_IDLE:  pg_onehot = 4'h1;
         PG_DECEL: pg_onehot = 4'h2;
         PG_ACCEL: pg_onehot = 4'h4;
         PG_CONST: pg_onehot = 4'h8;
         default:  pg_onehot = 4'h0;
      endcase
   end

   // Action word assembly, reserved bits zero
   always_comb begin
      action_nxt                                 = 16'h0000;
      action_nxt[4:0]                            = i_error_class_active;
      action_nxt[BIT_STANDSTILL]                 = standstill;
      action_nxt[BIT_MOVE_POS]                   = move_pos;
      action_nxt[BIT_MOVE_NEG]                   = move_neg;
      action_nxt[BIT_PG_CONST:BIT_PG_IDLE]       = pg_onehot;
   end

   // Illegal mode codes read as reserved
   assign mode_nxt = mode_legal(i_op_mode) ? i_op_mode : MODE_RESERVED;

   // SAFE_TORQUE_OFF input status code
   assign sto_nxt = !sto_p_r ? STO_ABSENT :
                    (sto_c_r ? STO_CONNECTED : STO_JUMPERED);

   // Local I/O bits
   assign lio_nxt = {14'h0000, local_signal_two_r, local_signal_one_r};

   // Newest class-0 code held until fault reset; a new event wins
   assign warn_nxt = i_class0_event ? i_class0_code :
                     (i_fault_reset ? NO_WARNING : warn_r);

   // Acceleration sign follows the ramp velocity change
   assign acc_nxt = 32'(i_ramp_velocity - i_ramp_velocity_prev);

   // ****************************************
   // Status registers
   // ****************************************
   logic [15:0] access_r;
   logic [15:0] action_r;
   logic [15:0] mode_r;
   logic [31:0] mac_hi_r;
   logic [31:0] mac_lo_r;
   logic [15:0] sto_r;
   logic [15:0] lio_r;
   logic [15:0] ovl_r;
   logic [15:0] load_r;
   logic [15:0] torque_current_actual_r;
   logic [15:0] field_current_actual_r;
   logic [15:0] idq_act_r;
   logic [15:0] vel_r;
   logic [15:0] torque_current_reference_r;
   logic [15:0] field_current_reference_r;
   logic [31:0] ramp_r;
   logic [31:0] acc_r;

   // Access, action and mode words; bus writes never reach these
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         access_r <= RESET_WORD[15:0];
         action_r <= RESET_WORD[15:0];
         mode_r   <= MODE_RESERVED;
      end else begin
         access_r <= access_nxt;
         action_r <= action_nxt;
         mode_r   <= mode_nxt;
      end
   end

   // MAC words, first byte most significant
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mac_hi_r <= RESET_WORD;
         mac_lo_r <= RESET_WORD;
      end else begin
         mac_hi_r <= {16'h0000, i_mac_address[47:32]};
         mac_lo_r <= i_mac_address[31:0];
      end
   end

   // Filtered pin words
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sto_r <= STO_ABSENT;
         lio_r <= RESET_WORD[15:0];
      end else begin
         sto_r <= sto_nxt;
         lio_r <= lio_nxt;
      end
   end

   // Last class-0 warning, kept after the error clears
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         warn_r <= NO_WARNING;
      end else begin
         warn_r <= warn_nxt;
      end
   end

   // Motor load figures
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ovl_r  <= RESET_WORD[15:0];
         load_r <= RESET_WORD[15:0];
      end else begin
         ovl_r  <= i_overload_pct;
         load_r <= i_load_pct;
      end
   end

   // Actual currents, signed steps of 0.01 peak ampere
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         torque_current_actual_r  <= RESET_WORD[15:0];
         field_current_actual_r  <= RESET_WORD[15:0];
         idq_act_r <= RESET_WORD[15:0];
      end else begin
         torque_current_actual_r  <= i_torque_current_actual;
         field_current_actual_r  <= i_field_current_actual;
         idq_act_r <= i_idq_act;
      end
   end

   // Reference currents, same scaling
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         torque_current_reference_r <= RESET_WORD[15:0];
         field_current_reference_r <= RESET_WORD[15:0];
      end else begin
         torque_current_reference_r <= i_torque_current_reference;
         field_current_reference_r <= i_field_current_reference;
      end
   end

   // Velocities and ramp acceleration
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         vel_r  <= RESET_WORD[15:0];
         ramp_r <= RESET_WORD;
         acc_r  <= RESET_WORD;
      end else begin
         vel_r  <= i_velocity;
         ramp_r <= i_ramp_velocity;
         acc_r  <= acc_nxt;
      end
   end

   // ****************************************
   // Parameter read port
   // ****************************************
   logic [31:0] rd_mux;
   logic        rd_hit;
   logic        wr_seen;

   // Address decode; 16-bit values sign or zero extended as stored
   always_comb begin
      rd_hit = 1'b1;
      case (i_par_addr)
         ADR_ACCESS_INFO:  rd_mux = {16'h0000, access_r};
         ADR_STO_STATUS:   rd_mux = {16'h0000, sto_r};
         ADR_LOCAL_IO:     rd_mux = {16'h0000, lio_r};
         ADR_MAC_HIGH:     rd_mux = mac_hi_r;
         ADR_MAC_LOW:      rd_mux = mac_lo_r;
         ADR_OP_MODE:      rd_mux = {{16{mode_r[15]}}, mode_r};
         ADR_ACTION_WORD:  rd_mux = {16'h0000, action_r};
         ADR_LAST_WARNING: rd_mux = {16'h0000, warn_r};
         ADR_OVERLOAD:     rd_mux = {{16{ovl_r[15]}}, ovl_r};
         ADR_LOAD:         rd_mux = {{16{load_r[15]}}, load_r};
         ADR_TORQUE_CURRENT_ACTUAL:       rd_mux = {{16{torque_current_actual_r[15]}}, torque_current_actual_r};
         ADR_FIELD_CURRENT_ACTUAL:       rd_mux = {{16{field_current_actual_r[15]}}, field_current_actual_r};
         ADR_IDQ_ACT:      rd_mux = {{16{idq_act_r[15]}}, idq_act_r};
         ADR_VEL_ACT:      rd_mux = {{16{vel_r[15]}}, vel_r};
         ADR_TORQUE_CURRENT_REFERENCE:       rd_mux = {{16{torque_current_reference_r[15]}}, torque_current_reference_r};
         ADR_FIELD_CURRENT_REFERENCE:       rd_mux = {{16{field_current_reference_r[15]}}, field_current_reference_r};
         ADR_RAMP_VEL:     rd_mux = ramp_r;
         ADR_REF_ACC:      rd_mux = acc_r;
         default: begin
            rd_mux = RESET_WORD;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Writes are refused; data is discarded
   assign wr_seen = i_par_wr && (i_par_wdata == i_par_wdata);

   // Registered answer one cycle after the request
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_par_rdata <= RESET_WORD;
         o_par_ack   <= 1'b0;
         o_par_err   <= 1'b0;
      end else begin
         o_par_rdata <= i_par_rd ? rd_mux : RESET_WORD;
         o_par_ack   <= i_par_rd || wr_seen;
         o_par_err   <= wr_seen || (i_par_rd && !rd_hit);
      end
   end

endmodule

`default_nettype wire

// ---- verilog/status_bank_pkg.sv ----
// Constants for the drive status parameter bank.
// Assumes word addresses on the parameter port match the fieldbus parameter map.
package status_bank_pkg;

   // ****************************************
   // Parameter addresses
   // ****************************************
   localparam logic [15:0] ADR_ACCESS_INFO   = 16'h0118;
   localparam logic [15:0] ADR_STO_STATUS    = 16'h0828;
   localparam logic [15:0] ADR_LOCAL_IO      = 16'h082A;
   localparam logic [15:0] ADR_MAC_HIGH      = 16'h1A10;
   localparam logic [15:0] ADR_MAC_LOW       = 16'h1A12;
   localparam logic [15:0] ADR_OP_MODE       = 16'h1B08;
   localparam logic [15:0] ADR_ACTION_WORD   = 16'h1C08;
   localparam logic [15:0] ADR_LAST_WARNING  = 16'h1C12;
   localparam logic [15:0] ADR_OVERLOAD      = 16'h1C32;
   localparam logic [15:0] ADR_LOAD          = 16'h1C34;
   localparam logic [15:0] ADR_TORQUE_CURRENT_ACTUAL        = 16'h1E02;
   localparam logic [15:0] ADR_FIELD_CURRENT_ACTUAL        = 16'h1E04;
   localparam logic [15:0] ADR_IDQ_ACT       = 16'h1E06;
   localparam logic [15:0] ADR_VEL_ACT       = 16'h1E10;
   localparam logic [15:0] ADR_TORQUE_CURRENT_REFERENCE        = 16'h1E20;
   localparam logic [15:0] ADR_FIELD_CURRENT_REFERENCE        = 16'h1E22;
   localparam logic [15:0] ADR_RAMP_VEL      = 16'h1F0C;
   localparam logic [15:0] ADR_REF_ACC       = 16'h1F12;

   // ****************************************
   // Field positions and codes
   // ****************************************
   localparam int          BIT_STANDSTILL    = 6;
   localparam int          BIT_MOVE_POS      = 7;
   localparam int          BIT_MOVE_NEG      = 8;
   localparam int          BIT_PG_IDLE       = 11;
   localparam int          BIT_PG_DECEL      = 12;
   localparam int          BIT_PG_ACCEL      = 13;
   localparam int          BIT_PG_CONST      = 14;
   localparam logic [15:0] STANDSTILL_RPM    = 16'h0009;
   localparam logic [7:0]  EXCL_NONE         = 8'h00;
   localparam logic [7:0]  EXCL_HELD         = 8'h01;
   localparam logic [15:0] STO_ABSENT        = 16'h0000;
   localparam logic [15:0] STO_JUMPERED      = 16'h0001;
   localparam logic [15:0] STO_CONNECTED     = 16'h0003;
   localparam logic [15:0] MODE_SPEED        = 16'hFFFC;
   localparam logic [15:0] MODE_JOG          = 16'hFFFF;
   localparam logic [15:0] MODE_PROFILE_POS  = 16'h0001;
   localparam logic [15:0] MODE_PROFILE_VEL  = 16'h0003;
   localparam logic [15:0] MODE_HOMING       = 16'h0006;
   localparam logic [15:0] MODE_RESERVED     = 16'h0000;
   localparam logic [15:0] NO_WARNING        = 16'h0000;
   localparam logic [31:0] RESET_WORD        = 32'h0000_0000;

   // Profile generator state
   typedef enum logic [1:0] {
      PG_IDLE  = 2'b00,
      PG_DECEL = 2'b01,
      PG_ACCEL = 2'b10,
      PG_CONST = 2'b11
   } pg_state_t;

endpackage

// ---- tb/status_bank_sva.sv ----
// Checker for the status bank parameter port and field placement.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module status_bank_sva
   import status_bank_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic        i_par_rd,
   input wire logic        i_par_wr,
   input wire logic [15:0] i_par_addr,
   input wire logic [31:0] o_par_rdata,
   input wire logic        o_par_ack,
   input wire logic        o_par_err,
   input wire logic        i_excl_access,
   input wire logic [7:0]  i_access_channel,
   input wire logic [4:0]  i_error_class_active,
   input wire logic [47:0] i_mac_address
);
   // Slices of the MAC address input
   wire logic [15:0] mac_top  = i_mac_address[47:32];
   wire logic [31:0] mac_rest = i_mac_address[31:0];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // ****************************************
   // Answer timing and read data placement
   // ****************************************
   a_ack_follows_req: assert property ((i_par_rd || i_par_wr) |=> o_par_ack)
      else $error("no ack after request");
   a_ack_quiet_idle: assert property (!(i_par_rd || i_par_wr) |=> !o_par_ack && !o_par_err)
      else $error("ack or err without request");
   a_write_refused: assert property (i_par_wr |=> o_par_err && o_par_rdata == 32'h0)
      else $error("write not refused");
   a_excl_byte: assert property (i_par_rd && i_par_addr == ADR_ACCESS_INFO && $past(i_nrst)
      |=> o_par_rdata[7:0] == {7'h00, $past(i_excl_access, 2)}) else $error("bad access low byte");
   a_channel_byte: assert property (i_par_rd && i_par_addr == ADR_ACCESS_INFO && $past(i_nrst)
      |=> o_par_rdata[31:8] == {16'h0000, $past(i_access_channel, 2)})
      else $error("bad access channel byte");
   a_err_class_bits: assert property (i_par_rd && i_par_addr == ADR_ACTION_WORD && $past(i_nrst)
      |=> o_par_rdata[4:0] == $past(i_error_class_active, 2)) else $error("bad error class bits");
   a_mac_high_word: assert property (i_par_rd && i_par_addr == ADR_MAC_HIGH && $past(i_nrst)
      |=> o_par_rdata == {16'h0000, $past(mac_top, 2)}) else $error("bad mac high word");
   a_mac_low_word: assert property (i_par_rd && i_par_addr == ADR_MAC_LOW && $past(i_nrst)
      |=> o_par_rdata == $past(mac_rest, 2)) else $error("bad mac low word");
   // Main scenarios reached
   c_write: cover property (i_par_wr ##1 o_par_err);
   c_access_read: cover property (i_par_rd && i_par_addr == ADR_ACCESS_INFO ##1 o_par_ack);
   c_good_read: cover property (i_par_rd ##1 o_par_ack && !o_par_err);
endmodule
bind drive_status_parameter_bank status_bank_sva chk (.*);
`default_nettype wire

// ---- tb/fieldbus_master_model.sv ----
// Fieldbus master model driving the parameter access port.
// Assumes the bank answers one cycle after the taking edge.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_rdata,
   input  wire logic        i_ack,
   input  wire logic        i_err,
   output logic             o_rd,
   output logic             o_wr,
   output logic [15:0]      o_addr,
   output logic [31:0]      o_wdata
);
   // ****************************************
   // Bus idle state and single access
   // ****************************************
   initial begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 16'h0000;
      o_wdata = 32'h0000_0000;
   end
   // One pulse, address held to the answer, then scrambled
   task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data,
                         output logic [31:0] q, output logic [1:0] resp);
      @(posedge i_clk);
      o_rd <= !wr;
      o_wr <= wr;
      o_addr <= addr;
      o_wdata <= data;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      @(posedge i_clk);
      q = i_rdata; // Taken at the edge where the answer stands
      resp = {i_ack, i_err};
      o_addr <= ~addr;
      o_wdata <= ~data;
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_drive_status_parameter_bank.sv ----
// Self-checking bench for the status parameter bank.
// Assumes the fieldbus master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_status_parameter_bank
   import status_bank_pkg::*;
;
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_par_rd, i_par_wr, o_par_ack, o_par_err;
   logic [15:0] i_par_addr, i_op_mode, i_class0_code, i_overload_pct, i_load_pct;
   logic [15:0] i_torque_current_actual, i_field_current_actual, i_idq_act, i_velocity, i_torque_current_reference, i_field_current_reference;
   logic [31:0] i_par_wdata, o_par_rdata, i_ramp_velocity, i_ramp_velocity_prev;
   logic        i_excl_access, i_sto_present, i_sto_connected, i_local_signal_one;
   logic        i_local_signal_two, i_class0_event, i_fault_reset;
   logic [7:0]  i_access_channel;
   logic [4:0]  i_error_class_active;
   logic [1:0]  i_pg_state;
   logic [47:0] i_mac_address;
   int          n_errors = 0, check_count = 0, cycles = 0;
   logic [7:0]  chans [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0A, 8'h0F};
   logic [15:0] vels [6] = '{16'h0064, 16'hFFFB, 16'hFF9C, 16'h0008, 16'h0009, 16'hFFF7};
   logic [15:0] acts [6] = '{16'h2080, 16'h0840, 16'h1100, 16'h4040, 16'h4080, 16'h0900};
   logic [1:0]  pgs [6] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h3, 2'h0};
   logic [15:0] modes [6] = '{MODE_SPEED, MODE_JOG, MODE_PROFILE_POS, MODE_PROFILE_VEL,
                              MODE_HOMING, 16'h0002};
   // ****************************************
   // Clock, instances and access tasks
   // ****************************************
   always #12.5 i_clk = ~i_clk;
   fieldbus_master_model master (
      .i_clk   (i_clk),
      .i_rdata (o_par_rdata),
      .i_ack   (o_par_ack),
      .i_err   (o_par_err),
      .o_rd    (i_par_rd),
      .o_wr    (i_par_wr),
      .o_addr  (i_par_addr),
      .o_wdata (i_par_wdata)
   );
   drive_status_parameter_bank dut (.*);
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic err = 1'b0);
      logic [31:0] q;
      logic [1:0]  r;
      master.access(1'b0, a, 32'h0, q, r);
      chk(q, exp);
      chk({30'h0, r}, {30'h0, 1'b1, err});
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      master.access(1'b1, a, d, q, r);
      chk(q, 32'h0);
      chk({30'h0, r}, {30'h0, 2'h3});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Cut a hang short
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_errors++;
         wrap_up();
      end
   end
   // Main sequence
   initial begin
      {i_excl_access, i_access_channel, i_error_class_active, i_pg_state, i_op_mode,
       i_mac_address, i_sto_present, i_sto_connected, i_local_signal_one, i_local_signal_two,
       i_class0_event, i_class0_code, i_fault_reset, i_overload_pct, i_load_pct, i_torque_current_actual,
       i_field_current_actual, i_idq_act, i_velocity, i_torque_current_reference, i_field_current_reference, i_ramp_velocity,
       i_ramp_velocity_prev} = '0;
      step(10);
      i_nrst <= 1'b1;
      i_mac_address <= 48'h1122_3344_5566;
      i_torque_current_actual <= 16'hFF9C;
      i_field_current_actual <= 16'h0064;
      i_idq_act <= 16'h0123;
      i_torque_current_reference <= 16'hFF00;
      i_field_current_reference <= 16'h0010;
      i_overload_pct <= 16'h0050;
      i_load_pct <= 16'hFFF0;
      i_ramp_velocity <= 32'h0000_0064;
      i_ramp_velocity_prev <= 32'h0000_0028;
      rd(ADR_LAST_WARNING, 32'h0);
      rd(ADR_MAC_HIGH, 32'h0000_1122);
      rd(ADR_MAC_LOW, 32'h3344_5566);
      rd(ADR_TORQUE_CURRENT_ACTUAL, 32'hFFFF_FF9C);
      rd(ADR_FIELD_CURRENT_ACTUAL, 32'h0000_0064);
      rd(ADR_IDQ_ACT, 32'h0000_0123);
      rd(ADR_TORQUE_CURRENT_REFERENCE, 32'hFFFF_FF00);
      rd(ADR_FIELD_CURRENT_REFERENCE, 32'h0000_0010);
      rd(ADR_OVERLOAD, 32'h0000_0050);
      rd(ADR_LOAD, 32'hFFFF_FFF0);
      rd(ADR_RAMP_VEL, 32'h0000_0064);
      rd(ADR_REF_ACC, 32'h0000_003C);
      i_ramp_velocity <= 32'h0000_0028;
      i_ramp_velocity_prev <= 32'h0000_0064;
      rd(ADR_REF_ACC, 32'hFFFF_FFC4);
      foreach (chans[k]) begin
         i_access_channel <= chans[k];
         i_excl_access <= chans[k][0];
         rd(ADR_ACCESS_INFO, {16'h0, chans[k], 7'h0, chans[k][0]});
      end
      foreach (vels[k]) begin
         i_velocity <= vels[k];
         i_pg_state <= pgs[k];
         i_error_class_active <= 5'(1 << k);
         rd(ADR_ACTION_WORD, {16'h0, acts[k] | {11'h0, 5'(1 << k)}});
         rd(ADR_VEL_ACT, {{16{vels[k][15]}}, vels[k]});
      end
      foreach (modes[k]) begin
         i_op_mode <= modes[k];
         rd(ADR_OP_MODE, (k == 5) ? 32'h0 : {{16{modes[k][15]}}, modes[k]});
      end
      for (int k = 0; k < 3; k++) begin
         i_sto_present <= (k != 0);
         i_sto_connected <= (k == 2);
         i_local_signal_one <= k[0];
         i_local_signal_two <= k[1];
         step(6);
         rd(ADR_STO_STATUS, (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : 32'h3);
         rd(ADR_LOCAL_IO, 32'(k));
      end
      i_class0_code <= 16'h1234;
      i_class0_event <= 1'b1;
      step(1);
      i_class0_event <= 1'b0;
      i_class0_code <= 16'h0000;
      rd(ADR_LAST_WARNING, 32'h0000_1234);
      i_fault_reset <= 1'b1;
      step(1);
      i_fault_reset <= 1'b0;
      rd(ADR_LAST_WARNING, 32'h0);
      i_class0_code <= 16'h0A02;
      i_class0_event <= 1'b1;
      i_fault_reset <= 1'b1;
      step(1);
      i_class0_event <= 1'b0;
      i_fault_reset <= 1'b0;
      rd(ADR_LAST_WARNING, 32'h0000_0A02);
      wr(ADR_ACTION_WORD, 32'h0000_0032);
      rd(ADR_ACTION_WORD, 32'h0000_0900);
      wr(ADR_MAC_LOW, 32'h0000_0050);
      rd(ADR_MAC_LOW, 32'h3344_5566);
      rd(16'h0000, 32'h0, 1'b1);
      i_nrst <= 1'b0;
      step(2);
      i_nrst <= 1'b1;
      rd(ADR_LAST_WARNING, 32'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
